// ==== rtl/uartb_consts.svh ====
`ifndef UARTB_CONSTS_SVH
`define UARTB_CONSTS_SVH
// Control register bit positions
`define UARTB_CTL_MODE 7
`define UARTB_CTL_UNUSED 6
`define UARTB_CTL_MCE 5
`define UARTB_CTL_REN 4
`define UARTB_CTL_TB8 3
`define UARTB_CTL_RB8 2
`define UARTB_CTL_TI 1
`define UARTB_CTL_RI 0
`define UARTB_CTL_RESET 8'h40
// Timer clock source codes
`define UARTB_SRC_DIV12 3'h0
`define UARTB_SRC_DIV4 3'h1
`define UARTB_SRC_DIV48 3'h2
`define UARTB_SRC_EXT8 3'h3
`define UARTB_SRC_PIN 3'h4
// Prescaler terminal counts
`define UARTB_DIV4_LAST 6'h03
`define UARTB_DIV12_LAST 6'h0b
`define UARTB_DIV48_LAST 6'h2f
`define UARTB_EXT8_LAST 3'h7
// Timer full-scale value
`define UARTB_TIMER_TOP 8'hff
// Receive samples per bit, in overflows
`define UARTB_OVF_PER_BIT 1'b1
`endif

// ==== rtl/uartb_pkg.sv ====
package uartb_pkg;
    typedef struct packed {
        logic frameWidthSelect;
        logic multiprocFilterEnable;
        logic receiveEnable;
        logic transmitNinthBit;
    } uartb_cfg_s;
    typedef struct packed {
        logic timerOneEnable;
        logic [2:0] clockSource;
        logic [7:0] timerOneReloadByte;
    } uartb_timer_s;
    typedef enum logic [2:0] {
        TX_IDLE = 3'b001,
        TX_SHIFT = 3'b010,
        TX_STOP = 3'b100
    } uartb_tx_e;
    typedef enum logic [2:0] {
        RX_IDLE = 3'b001,
        RX_SHIFT = 3'b010,
        RX_STOP = 3'b100
    } uartb_rx_e;
endpackage : uartb_pkg

// ==== rtl/uartb_timer.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "uartb_consts.svh"
module uartb_timer (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Tick, reload and forced reload
    input wire logic tick,
    input wire logic [7:0] reloadByte,
    input wire logic forceReload,
    // Overflow pulse and count
    output logic overflow,
    output logic [7:0] count
);
    logic [7:0] count_reg;
    logic overflow_reg;
    always_ff @(posedge clk)
    begin
        if (rst)
            count_reg <= 8'h00;
        else if (forceReload)
            count_reg <= reloadByte;
        else if (tick)
            count_reg <= (count_reg == `UARTB_TIMER_TOP) ? reloadByte : count_reg + 8'h01;
    end
    always_ff @(posedge clk)
    begin
        if (rst)
            overflow_reg <= 1'b0;
        else
            overflow_reg <= tick && !forceReload && (count_reg == `UARTB_TIMER_TOP);
    end
    assign overflow = overflow_reg;
    assign count = count_reg;
endmodule : uartb_timer
`default_nettype wire

// ==== rtl/uartb_core.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "uartb_consts.svh"
module uartb_core
    import uartb_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Configuration
    input wire uartb_pkg::uartb_cfg_s cfg,
    input wire uartb_pkg::uartb_timer_s timerCfg,
    // Timer clock sources, synchronous to clk
    input wire logic extOscClock,
    input wire logic timerOneInputPin,
    // Serial data buffer access
    input wire logic dataWrite,
    input wire logic [7:0] dataWriteValue,
    input wire logic dataRead,
    output logic [7:0] serialDataBuffer,
    // Flag clears and interrupt enable from software
    input wire logic clearTransmitDone,
    input wire logic clearReceiveDone,
    input wire logic interruptEnable,
    // Status
    output logic transmitDoneFlag,
    output logic receiveDoneFlag,
    output logic receivedNinthBit,
    output logic [7:0] serialControlReg,
    output logic [7:0] timerOneLowCount,
    output logic interruptRequest,
    // Serial pins
    input wire logic serialReceivePin,
    output logic serialTransmitPin
);
    import uartb_pkg::*;
    logic [5:0] preCnt_reg;
    logic [2:0] extCnt_reg;
    logic extPrev_reg, pinPrev_reg, timerTick_reg;
    logic preWrap, extWrap, txOvf, rxOvf, rxStartEdge;
    logic txHalf_reg, rxHalf_reg, rxPrev_reg;
    logic txBaud, rxBaud;
    uartb_tx_e txState_reg;
    uartb_rx_e rxState_reg;
    logic [9:0] txShift_reg;
    logic [3:0] txCount_reg, rxCount_reg;
    logic [8:0] rxShift_reg;
    logic [7:0] rxBuffer_reg;
    logic txDone_reg, rxDone_reg, rb8_reg, irq_reg, txPin_reg;
    logic txDoneSet, rxDoneSet;
    logic [3:0] frameBits;
    function automatic logic [5:0] pre_last(input logic [2:0] src);
        case (src)
            `UARTB_SRC_DIV4: pre_last = `UARTB_DIV4_LAST;
            `UARTB_SRC_DIV48: pre_last = `UARTB_DIV48_LAST;
            default: pre_last = `UARTB_DIV12_LAST;
        endcase
    endfunction : pre_last
    assign preWrap = (preCnt_reg >= pre_last(timerCfg.clockSource));
    assign extWrap = (extCnt_reg == `UARTB_EXT8_LAST) && extOscClock && !extPrev_reg;
    always_ff @(posedge clk)
    begin
        if (rst)
            preCnt_reg <= 6'h00;
        else
            preCnt_reg <= preWrap ? 6'h00 : preCnt_reg + 6'h01;
    end
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            extCnt_reg <= 3'h0;
            extPrev_reg <= 1'b0;
            pinPrev_reg <= 1'b0;
        end
        else
        begin
            extPrev_reg <= extOscClock;
            pinPrev_reg <= timerOneInputPin;
            if (extOscClock && !extPrev_reg)
                extCnt_reg <= extCnt_reg + 3'h1;
        end
    end
    always_ff @(posedge clk)
    begin
        if (rst)
            timerTick_reg <= 1'b0;
        else if (!timerCfg.timerOneEnable)
            timerTick_reg <= 1'b0;
        else
            case (timerCfg.clockSource)
                `UARTB_SRC_EXT8: timerTick_reg <= extWrap;
                `UARTB_SRC_PIN: timerTick_reg <= timerOneInputPin && !pinPrev_reg;
                default: timerTick_reg <= preWrap;
            endcase
    end
    // Transmit auto-reload timer; overflow every 256-reload ticks
    uartb_timer txTimer (
        .clk(clk),
        .rst(rst),
        .tick(timerTick_reg),
        .reloadByte(timerCfg.timerOneReloadByte),
        .forceReload(1'b0),
        .overflow(txOvf),
        .count(timerOneLowCount)
    );
    assign rxStartEdge = (rxState_reg == RX_IDLE) && cfg.receiveEnable && rxPrev_reg && !serialReceivePin;
    // Hidden receive timer; same tick and reload; start reload
    uartb_timer rxTimer (
        .clk(clk),
        .rst(rst),
        .tick(timerTick_reg),
        .reloadByte(timerCfg.timerOneReloadByte),
        .forceReload(rxStartEdge),
        .overflow(rxOvf),
        .count()
    );
    // Divide overflows by two; a taken write restarts the tx phase so the start bit is never shorter than half a bit
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            txHalf_reg <= 1'b0;
            rxHalf_reg <= 1'b0;
        end
        else
        begin
            if (dataWrite && txState_reg == TX_IDLE)
                txHalf_reg <= 1'b0;
            else if (txOvf)
                txHalf_reg <= !txHalf_reg;
            if (rxStartEdge)
                rxHalf_reg <= 1'b0;
            else if (rxOvf)
                rxHalf_reg <= !rxHalf_reg;
        end
    end
    assign txBaud = txOvf && txHalf_reg;
    // Receive samples mid-bit: first overflow after the start edge is half a bit in
    assign rxBaud = rxOvf && !rxHalf_reg;
    // Frame width select; ten or eleven bits
    assign frameBits = cfg.frameWidthSelect ? 4'h9 : 4'h8;
    assign txDoneSet = (txState_reg == TX_SHIFT) && txBaud && (txCount_reg == frameBits);
    // Write starts transmission; start, data LSB first, stop
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            txState_reg <= TX_IDLE;
            txShift_reg <= 10'h3ff;
            txCount_reg <= 4'h0;
            txPin_reg <= 1'b1;
        end
        else
            case (txState_reg)
                TX_IDLE:
                begin
                    txPin_reg <= 1'b1;
                    if (dataWrite)
                    begin
                        txShift_reg <= {1'b1, cfg.transmitNinthBit, dataWriteValue};
                        txCount_reg <= 4'h0;
                        txState_reg <= TX_SHIFT;
                        txPin_reg <= 1'b0;
                    end
                end
                TX_SHIFT:
                    if (txBaud)
                    begin
                        if (txCount_reg == frameBits)
                        begin
                            txPin_reg <= 1'b1;
                            txState_reg <= TX_STOP;
                        end
                        else
                        begin
                            txPin_reg <= txShift_reg[0];
                            txShift_reg <= {1'b1, txShift_reg[9:1]};
                            txCount_reg <= txCount_reg + 4'h1;
                        end
                    end
                TX_STOP:
                    if (txBaud)
                        txState_reg <= TX_IDLE;
                default:
                    txState_reg <= TX_IDLE;
            endcase
    end
    // Shift register independent of buffer; idle line tracking
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rxState_reg <= RX_IDLE;
            rxShift_reg <= 9'h000;
            rxCount_reg <= 4'h0;
            rxPrev_reg <= 1'b1;
        end
        else
        begin
            rxPrev_reg <= serialReceivePin;
            case (rxState_reg)
                RX_IDLE:
                    if (rxStartEdge)
                    begin
                        rxCount_reg <= 4'h0;
                        rxState_reg <= RX_SHIFT;
                    end
                RX_SHIFT:
                    if (rxBaud)
                    begin
                        if (rxCount_reg == 4'h0 && serialReceivePin)
                            rxState_reg <= RX_IDLE;
                        else if (rxCount_reg == frameBits + 4'h1)
                            rxState_reg <= RX_STOP;
                        else
                            rxShift_reg <= {serialReceivePin, rxShift_reg[8:1]};
                        rxCount_reg <= rxCount_reg + 4'h1;
                    end
                RX_STOP:
                    rxState_reg <= RX_IDLE;
                default:
                    rxState_reg <= RX_IDLE;
            endcase
        end
    end
    // Load only if flag clear and filter passes
    assign rxDoneSet = (rxState_reg == RX_STOP) && !rxDone_reg &&
        (!cfg.multiprocFilterEnable || (cfg.frameWidthSelect ? rxShift_reg[8] : rxPrev_reg));
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rxBuffer_reg <= 8'h00;
            rb8_reg <= 1'b0;
        end
        else if (rxDoneSet)
        begin
            rxBuffer_reg <= cfg.frameWidthSelect ? rxShift_reg[7:0] : rxShift_reg[8:1];
            rb8_reg <= cfg.frameWidthSelect ? rxShift_reg[8] : rxPrev_reg;
        end
    end
    // Tx done at stop start, rx done after stop sample; software clear only, set wins
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            txDone_reg <= 1'b0;
            rxDone_reg <= 1'b0;
        end
        else
        begin
            if (txDoneSet)
                txDone_reg <= 1'b1;
            else if (clearTransmitDone)
                txDone_reg <= 1'b0;
            if (rxDoneSet)
                rxDone_reg <= 1'b1;
            else if (clearReceiveDone)
                rxDone_reg <= 1'b0;
        end
    end
    always_ff @(posedge clk)
    begin
        if (rst)
            irq_reg <= 1'b0;
        else
            irq_reg <= interruptEnable && (txDone_reg || rxDone_reg);
    end
    // Read path shows receive buffer only
    assign serialDataBuffer = rxBuffer_reg;
    assign transmitDoneFlag = txDone_reg;
    assign receiveDoneFlag = rxDone_reg;
    assign receivedNinthBit = rb8_reg;
    assign interruptRequest = irq_reg;
    assign serialTransmitPin = txPin_reg;
    assign serialControlReg = {cfg.frameWidthSelect, 1'b1, cfg.multiprocFilterEnable, cfg.receiveEnable,
        cfg.transmitNinthBit, rb8_reg, txDone_reg, rxDone_reg};
endmodule : uartb_core
`default_nettype wire

// ==== bench/uartb_props.sv ====
`timescale 1ns/10ps
`default_nettype none
module uartb_props
    import uartb_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Inputs
    input wire uartb_pkg::uartb_cfg_s cfg,
    input wire uartb_pkg::uartb_timer_s timerCfg,
    input wire logic dataWrite,
    input wire logic clearTransmitDone,
    input wire logic clearReceiveDone,
    input wire logic interruptEnable,
    // Outputs
    input wire logic transmitDoneFlag,
    input wire logic receiveDoneFlag,
    input wire logic receivedNinthBit,
    input wire logic [7:0] serialDataBuffer,
    input wire logic [7:0] serialControlReg,
    input wire logic [7:0] timerOneLowCount,
    input wire logic interruptRequest,
    input wire logic serialTransmitPin
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic anyFlag;
    assign anyFlag = transmitDoneFlag | receiveDoneFlag;
    a_irq_raise: assert property (interruptEnable && anyFlag |=> interruptRequest)
        else $error("interrupt not raised");
    a_irq_quiet: assert property (!(interruptEnable && anyFlag) |=> !interruptRequest)
        else $error("interrupt without cause");
    a_flags_hold: assert property ((transmitDoneFlag && !clearTransmitDone |=> transmitDoneFlag)
        and (receiveDoneFlag && !clearReceiveDone |=> receiveDoneFlag)) else $error("flag dropped");
    a_rxbuf_kept: assert property (receiveDoneFlag && !clearReceiveDone |=> $stable(serialDataBuffer))
        else $error("buffer overwritten");
    a_rxbuf_cause: assert property ($changed(serialDataBuffer) |-> $rose(receiveDoneFlag))
        else $error("buffer changed without reception");
    a_ctl_view: assert property (serialControlReg == {cfg.frameWidthSelect, 1'b1,
        cfg.multiprocFilterEnable, cfg.receiveEnable, cfg.transmitNinthBit, receivedNinthBit,
        transmitDoneFlag, receiveDoneFlag}) else $error("control view wrong");
    a_done_stop: assert property ($rose(transmitDoneFlag) |-> serialTransmitPin)
        else $error("done flag outside stop bit");
    a_tmr_reload: assert property ($changed(timerOneLowCount) && $past(timerOneLowCount) == 8'hff
        |-> timerOneLowCount == timerCfg.timerOneReloadByte) else $error("timer reload wrong");
    a_tmr_step: assert property ($changed(timerOneLowCount) && $past(timerOneLowCount) != 8'hff
        |-> timerOneLowCount == $past(timerOneLowCount) + 8'h01) else $error("timer step wrong");
    a_tick_gap: assert property ($changed(timerOneLowCount) |=> $stable(timerOneLowCount)[*3])
        else $error("timer ticks too fast");
    cover property (dataWrite ##1 !serialTransmitPin);
    cover property ($rose(receiveDoneFlag));
    cover property ($rose(interruptRequest));
endmodule : uartb_props
bind uartb_core uartb_props u_props (.clk(clk), .rst(rst), .cfg(cfg), .timerCfg(timerCfg),
    .dataWrite(dataWrite), .clearTransmitDone(clearTransmitDone), .clearReceiveDone(clearReceiveDone),
    .interruptEnable(interruptEnable), .transmitDoneFlag(transmitDoneFlag), .receiveDoneFlag(receiveDoneFlag),
    .receivedNinthBit(receivedNinthBit), .serialDataBuffer(serialDataBuffer), .serialControlReg(serialControlReg),
    .timerOneLowCount(timerOneLowCount), .interruptRequest(interruptRequest), .serialTransmitPin(serialTransmitPin));
`default_nettype wire

// ==== bench/uartb_peer.sv ====
`timescale 1ns/10ps
`default_nettype none
module uartb_peer #(
    parameter int BIT_CYC = 16
) (
    // Clock
    input wire logic clk,
    // Lines
    input wire logic txLine,
    output logic rxLine
);
    logic [8:0] got;
    logic nine;
    int nGot;
    initial
    begin
        rxLine = 1'b1;
        nine = 1'b0;
        nGot = 0;
        got = '0;
    end
    task automatic send(input logic [8:0] v, input int n);
        for (int i = 0; i < n + 2; i++)
        begin
            rxLine <= (i == 0) ? 1'b0 : (i > n) ? 1'b1 : v[i - 1];
            repeat (BIT_CYC) @(posedge clk);
        end
        // Hand back just after the edge, like every other stimulus
        #1;
    endtask : send
    // Mid-bit sampling; offset absorbs the unaligned start bit
    initial
    forever
    begin
        @(negedge txLine);
        got = '0;
        repeat (BIT_CYC + BIT_CYC / 4) @(posedge clk);
        for (int i = 0; i < (nine ? 9 : 8); i++)
        begin
            #1 got[i] = txLine;
            repeat (BIT_CYC) @(posedge clk);
        end
        wait (txLine);
        nGot++;
    end
endmodule : uartb_peer
`default_nettype wire

// ==== bench/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb;
    import uartb_pkg::*;
    logic clk, rst, extOscClock, timerOneInputPin, dataWrite, dataRead, serialReceivePin;
    logic clearTransmitDone, clearReceiveDone, interruptEnable, serialTransmitPin;
    logic transmitDoneFlag, receiveDoneFlag, receivedNinthBit, interruptRequest;
    logic [7:0] dataWriteValue, serialDataBuffer, serialControlReg, timerOneLowCount;
    uartb_cfg_s cfg;
    uartb_timer_s timerCfg;
    int failures, n_checks, pinDiv, n, was;
    int gapExp[5] = '{12, 4, 48, 16, 10};
    uartb_core dut (.clk(clk), .rst(rst), .cfg(cfg), .timerCfg(timerCfg), .extOscClock(extOscClock),
        .timerOneInputPin(timerOneInputPin), .dataWrite(dataWrite), .dataWriteValue(dataWriteValue),
        .dataRead(dataRead), .serialDataBuffer(serialDataBuffer), .clearTransmitDone(clearTransmitDone),
        .clearReceiveDone(clearReceiveDone), .interruptEnable(interruptEnable),
        .transmitDoneFlag(transmitDoneFlag), .receiveDoneFlag(receiveDoneFlag),
        .receivedNinthBit(receivedNinthBit), .serialControlReg(serialControlReg),
        .timerOneLowCount(timerOneLowCount), .interruptRequest(interruptRequest),
        .serialReceivePin(serialReceivePin), .serialTransmitPin(serialTransmitPin));
    uartb_peer #(.BIT_CYC(16)) peer (.clk(clk), .txLine(serialTransmitPin), .rxLine(serialReceivePin));
    always #2.5 clk = ~clk;
    // External oscillator at half the clock, timer pin period of ten cycles
    always @(posedge clk)
    begin
        extOscClock <= ~extOscClock;
        pinDiv <= (pinDiv == 4) ? 0 : pinDiv + 1;
        if (pinDiv == 4)
            timerOneInputPin <= ~timerOneInputPin;
    end
    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : step
    task automatic wr(input logic [7:0] v);
        dataWriteValue = v;
        dataWrite = 1'b1;
        step(1);
        dataWrite = 1'b0;
        step(1);
    endtask : wr
    task automatic clr();
        clearTransmitDone = 1'b1;
        clearReceiveDone = 1'b1;
        step(1);
        clearTransmitDone = 1'b0;
        clearReceiveDone = 1'b0;
    endtask : clr
    task automatic waitFlag(input bit rx, input int lim);
        for (n = 0; n < lim && (rx ? receiveDoneFlag : transmitDoneFlag) !== 1'b1; n++)
            step(1);
    endtask : waitFlag
    task automatic waitTx();
        was = peer.nGot;
        waitFlag(0, 400);
        for (int i = 0; i < 300 && peer.nGot == was; i++)
            step(1);
    endtask : waitTx
    task automatic waitTick();
        logic [7:0] c;
        c = timerOneLowCount;
        for (n = 0; n < 200 && timerOneLowCount === c; n++)
            step(1);
    endtask : waitTick
    task print_verdict();
        $display("Checks %0d, failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict
    initial
    begin
        #100000;
        failures++;
        print_verdict();
    end
    initial
    begin
        {clk, extOscClock, timerOneInputPin, dataWrite, dataRead, clearTransmitDone, clearReceiveDone} = '0;
        {rst, interruptEnable} = 2'b11;
        {pinDiv, failures, n_checks, dataWriteValue} = '0;
        cfg = '{1'b0, 1'b0, 1'b1, 1'b0};
        // Overflow every two timer ticks gives two overflows per bit
        timerCfg = '{1'b1, 3'h1, 8'hfe};
        repeat (3) @(posedge clk);
        #1 rst = 1'b0;
        chk({serialTransmitPin, transmitDoneFlag, receiveDoneFlag}, 9'h004);
        chk(serialControlReg, 9'h050);
        step(1100);
        wr(8'ha5);
        wr(8'h3c);
        chk(serialTransmitPin, 9'h000);
        waitTx();
        chk(9'(n >= 120 && n <= 146), 9'h001);
        chk(peer.got, 9'h0a5);
        chk(transmitDoneFlag, 9'h001);
        // Request follows the flag by one cycle
        step(1);
        chk(interruptRequest, 9'h001);
        step(200);
        chk(peer.nGot, 9'(was + 1));
        clr();
        peer.send(9'h05a, 8);
        waitFlag(1, 40);
        chk({receivedNinthBit, serialDataBuffer}, 9'h15a);
        peer.send(9'h077, 8);
        chk(serialDataBuffer, 9'h05a);
        interruptEnable = 1'b0;
        step(2);
        chk(interruptRequest, 9'h000);
        interruptEnable = 1'b1;
        clr();
        wr(8'h96);
        peer.send(9'h0c3, 8);
        waitFlag(1, 40);
        chk(serialDataBuffer, 9'h0c3);
        waitTx();
        chk(peer.got, 9'h096);
        clr();
        cfg = '{1'b1, 1'b1, 1'b1, 1'b1};
        peer.nine = 1'b1;
        peer.send(9'h033, 9);
        chk(receiveDoneFlag, 9'h000);
        peer.send(9'h144, 9);
        waitFlag(1, 40);
        chk({receivedNinthBit, serialDataBuffer}, 9'h144);
        wr(8'h81);
        waitTx();
        chk(peer.got, 9'h181);
        for (int s = 0; s < 5; s++)
        begin
            // Park the timer across the switch so no two ticks straddle two sources
            timerCfg.timerOneEnable = 1'b0;
            step(8);
            timerCfg = '{1'b1, 3'(s), 8'hfe};
            waitTick();
            waitTick();
            waitTick();
            chk(9'(n), 9'(gapExp[s]));
        end
        print_verdict();
    end
endmodule : tb
`default_nettype wire
